// ### hdl/lsc_pkg.sv
// Constants and types shared by the LED switch current configuration block
package lsc_pkg;

  // ************************************************************
  // Serial frame geometry
  // ************************************************************
  localparam int unsigned LSC_ADDR_W     = 7;
  localparam int unsigned LSC_DATA_W     = 8;
  localparam int unsigned LSC_CNT_W      = 3;
  localparam logic [2:0]  LSC_LAST_BIT   = 3'h7;
  localparam logic [2:0]  LSC_CNT_ZERO   = 3'h0;
  localparam logic [2:0]  LSC_CNT_ONE    = 3'h1;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [6:0]  LSC_LIMIT_ADDR    = 7'h02;
  localparam int unsigned LSC_NUM_SWITCHES  = 2;
  localparam logic [6:0]  LSC_UPPER_ADDR [LSC_NUM_SWITCHES] = '{7'h03, 7'h05};
  localparam logic [6:0]  LSC_LOWER_ADDR [LSC_NUM_SWITCHES] = '{7'h04, 7'h06};

  // ************************************************************
  // Field layout of the limit register
  // ************************************************************
  localparam int unsigned LSC_SEL_LSB    = 3;
  localparam int unsigned LSC_SEL_W      = 3;
  localparam int unsigned LSC_EN_LSB     = 0;
  localparam int unsigned LSC_EN_W       = 3;

  // ************************************************************
  // Field layout of the current code registers
  // ************************************************************
  localparam int unsigned LSC_CODE_W     = 10;
  localparam int unsigned LSC_UPPER_W    = 2;
  localparam int unsigned LSC_LOWER_W    = 8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [2:0]  LSC_SEL_RST    = 3'h5;
  localparam logic [2:0]  LSC_EN_RST     = 3'h0;
  localparam logic [9:0]  LSC_CODE_RST   = 10'h000;
  localparam logic [7:0]  LSC_BYTE_ZERO  = 8'h00;
  localparam logic [1:0]  LSC_RSVD_LIMIT = 2'h0;
  localparam logic [5:0]  LSC_RSVD_UPPER = 6'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    LSC_IDLE,
    LSC_ADDR,
    LSC_DATA,
    LSC_DONE
  } lsc_phase_type;

endpackage : lsc_pkg

// ### hdl/lsc_reg_bank.sv
// Register storage and read mux for the limit and current code registers
`timescale 1ns/10ps
module lsc_reg_bank
  import lsc_pkg::*;
(
  input  wire logic                         core_clk,
  input  wire logic                         reset_n,
  input  wire logic                         wr_en,
  input  wire logic [lsc_pkg::LSC_ADDR_W-1:0] wr_addr,
  input  wire logic [lsc_pkg::LSC_DATA_W-1:0] wr_data,
  input  wire logic [lsc_pkg::LSC_ADDR_W-1:0] rd_addr,
  output logic      [lsc_pkg::LSC_DATA_W-1:0] rd_data,
  output logic      [lsc_pkg::LSC_SEL_W-1:0]  limit_select,
  output logic      [lsc_pkg::LSC_EN_W-1:0]   limit_enable,
  output logic      [lsc_pkg::LSC_CODE_W-1:0] code_a,
  output logic      [lsc_pkg::LSC_CODE_W-1:0] code_b
);
  import lsc_pkg::*;

  typedef struct packed {
    logic [LSC_SEL_W-1:0]                         sel;
    logic [LSC_EN_W-1:0]                          en;
    logic [LSC_NUM_SWITCHES-1:0][LSC_CODE_W-1:0]  code;
  } lsc_bank_type;

  lsc_bank_type state;
  lsc_bank_type next_state;

  // Write decode; no unlock sequence guards these registers
  always_comb begin
    next_state = state;
    if (wr_en) begin
      if (wr_addr == LSC_LIMIT_ADDR) begin
        next_state.sel = wr_data[LSC_SEL_LSB +: LSC_SEL_W];   // RQ1 RQ12
        next_state.en  = wr_data[LSC_EN_LSB +: LSC_EN_W];     // RQ3 RQ4 RQ5
      end
      for (int i = 0; i < LSC_NUM_SWITCHES; i++) begin
        if (wr_addr == LSC_UPPER_ADDR[i]) begin
          // Only the two code bits are stored; bits 7..2 dropped
          next_state.code[i][LSC_CODE_W-1 -: LSC_UPPER_W] =
            wr_data[LSC_UPPER_W-1:0];                           // RQ6 RQ8 RQ13
        end
        if (wr_addr == LSC_LOWER_ADDR[i]) begin
          next_state.code[i][LSC_LOWER_W-1:0] = wr_data;      // RQ7 RQ9
        end
      end
    end
  end

  // Read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    rd_data = LSC_BYTE_ZERO;
    if (rd_addr == LSC_LIMIT_ADDR) begin
      rd_data = {LSC_RSVD_LIMIT, state.sel, state.en};        // RQ13
    end
    for (int i = 0; i < LSC_NUM_SWITCHES; i++) begin
      if (rd_addr == LSC_UPPER_ADDR[i]) begin
        rd_data = {LSC_RSVD_UPPER, state.code[i][LSC_CODE_W-1 -: LSC_UPPER_W]}; // RQ13
      end
      if (rd_addr == LSC_LOWER_ADDR[i]) begin
        rd_data = state.code[i][LSC_LOWER_W-1:0];
      end
    end
  end

  // State registers with documented defaults
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state.sel  <= LSC_SEL_RST;                              // RQ1 RQ11
      state.en   <= LSC_EN_RST;                               // RQ3 RQ4 RQ5
      state.code <= {LSC_NUM_SWITCHES{LSC_CODE_RST}};         // RQ6 RQ7 RQ8 RQ9
    end else begin
      state <= next_state;
    end
  end

  // Control values straight from the flops
  assign limit_select = state.sel;
  assign limit_enable = state.en;
  assign code_a       = state.code[0];                        // RQ10
  assign code_b       = state.code[1];                        // RQ10

endmodule : lsc_reg_bank

// ### hdl/lsc_config_top.sv
// Serial register port and current-limit configuration outputs of the LED switches
//
// Functional notes
// [RQ1] Three-bit transient limit selector, bits 5:3, reset 5
// [RQ2] Software keeps limit above regulation current
// [RQ3] Bit 2 enables third switch limit, reset 0
// [RQ4] Bit 1 enables second switch limit, reset 0
// [RQ5] Bit 0 enables first switch limit, reset 0
// [RQ6] Offset 03 holds first code bits 9:8
// [RQ7] Offset 04 holds first code bits 7:0
// [RQ8] Offset 05 holds second code bits 9:8
// [RQ9] Offset 06 holds second code bits 7:0
// [RQ10] Ten-bit code drives switch current DAC
// [RQ11] Limit register at offset 02, reset 28h
// [RQ12] Registers written directly, no password needed
// [RQ13] Reserved bits ignore writes, read zero
`timescale 1ns/10ps
module lsc_config_top
  import lsc_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic                          spi_sclk,
  input  wire logic                          spi_cs_n,
  input  wire logic                          spi_mosi,
  output logic                               spi_miso,
  output logic                               spi_miso_oe,
  output logic [lsc_pkg::LSC_SEL_W-1:0]      transient_limit_select,
  output logic                               switch_a_limit_enable,
  output logic                               switch_b_limit_enable,
  output logic                               switch_c_limit_enable,
  output logic [lsc_pkg::LSC_CODE_W-1:0]     switch_a_current_code,
  output logic [lsc_pkg::LSC_CODE_W-1:0]     switch_b_current_code
);
  import lsc_pkg::*;

  // ************************************************************
  // Serial decoder state
  // ************************************************************
  typedef struct packed {
    lsc_phase_type            phase;
    logic                     sclk_prev;
    logic [LSC_CNT_W-1:0]     bit_cnt;
    logic [LSC_DATA_W-1:0]    shift;
    logic [LSC_ADDR_W-1:0]    addr;
    logic                     is_write;
    logic                     load_pend;
    logic                     wr_en;
    logic                     miso;
    logic                     miso_oe;
  } lsc_spi_type;

  lsc_spi_type              state;
  lsc_spi_type              next_state;
  logic                     sclk_rise;
  logic                     sclk_fall;
  logic [LSC_DATA_W-1:0]    rd_data;
  logic [LSC_DATA_W-1:0]    rx_byte;
  logic [LSC_EN_W-1:0]      limit_enable;

  // Edge detection on the sampled serial clock
  assign sclk_rise = spi_sclk & ~state.sclk_prev;
  assign sclk_fall = ~spi_sclk & state.sclk_prev;
  assign rx_byte   = {state.shift[LSC_DATA_W-2:0], spi_mosi};

  // ************************************************************
  // Frame position decode
  // ************************************************************

  logic                     byte_last;
  logic                     data_started;
  logic                     read_fall;
  logic                     write_rise;
  logic [LSC_CNT_W-1:0]     bit_next;
  logic [LSC_ADDR_W-1:0]    addr_in;
  logic [LSC_DATA_W-1:0]    tx_next;

  // Eighth rise of a byte, address or data
  assign byte_last    = sclk_rise && (state.bit_cnt == LSC_LAST_BIT);

  // Counter has passed the first data rise
  assign data_started = (state.bit_cnt != LSC_CNT_ZERO);

  // Skips the fall after the address byte so bit 7 meets the first data rise
  assign read_fall    = sclk_fall && !state.is_write && data_started;

  // Write data shifts in on every data rise
  assign write_rise   = sclk_rise && state.is_write;

  // Bit counter wraps from last bit to zero at each byte
  assign bit_next     = state.bit_cnt + LSC_CNT_ONE;

  // Upper seven bits of the address byte, held before its last rise
  assign addr_in      = state.shift[LSC_ADDR_W-1:0];

  // Read byte moved one place toward the line
  assign tx_next      = {state.shift[LSC_DATA_W-2:0], 1'b0};

  // ************************************************************
  // Frame sequencer
  // ************************************************************

  // Address byte then one data byte per chip-select frame
  always_comb begin
    next_state           = state;
    next_state.sclk_prev = spi_sclk;
    next_state.wr_en     = 1'b0;
    if (spi_cs_n) begin
      // Deselect aborts any partial frame
      next_state.phase     = LSC_IDLE;
      next_state.bit_cnt   = LSC_CNT_ZERO;
      next_state.load_pend = 1'b0;
      next_state.miso      = 1'b0;
      next_state.miso_oe   = 1'b0;
    end else begin
      case (state.phase)
        LSC_IDLE: begin
          next_state.phase   = LSC_ADDR;
          next_state.bit_cnt = LSC_CNT_ZERO;
          next_state.miso_oe = 1'b1;
        end
        LSC_ADDR: begin
          if (sclk_rise) begin
            next_state.shift   = rx_byte;
            next_state.bit_cnt = bit_next;
            if (byte_last) begin
              // Upper seven bits address, lowest bit marks a write
              next_state.addr      = addr_in;
              next_state.is_write  = spi_mosi;
              next_state.load_pend = ~spi_mosi;
              next_state.phase     = LSC_DATA;
            end
          end
        end
        LSC_DATA: begin
          if (state.load_pend) begin
            // Present read data one core cycle after the address
            next_state.shift     = rd_data;
            next_state.miso      = rd_data[LSC_DATA_W-1];
            next_state.load_pend = 1'b0;
          end else if (read_fall) begin
            next_state.shift = tx_next;
            next_state.miso  = state.shift[LSC_DATA_W-2];
          end
          if (sclk_rise) begin
            next_state.bit_cnt = bit_next;
            if (write_rise) begin
              next_state.shift = rx_byte;
            end
            if (byte_last) begin
              // Plain write, no unlock step in front of it
              next_state.wr_en = state.is_write;               // RQ12
              next_state.phase = LSC_DONE;
            end
          end
        end
        LSC_DONE: begin
          // Extra clocks in the frame are ignored
          next_state.phase = LSC_DONE;
        end
        default: begin
          next_state.phase = LSC_IDLE;
        end
      endcase
    end
  end

  // Decoder registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state.phase     <= LSC_IDLE;
      state.sclk_prev <= 1'b0;
      state.bit_cnt   <= LSC_CNT_ZERO;
      state.shift     <= LSC_BYTE_ZERO;
      state.addr      <= LSC_LIMIT_ADDR;
      state.is_write  <= 1'b0;
      state.load_pend <= 1'b0;
      state.wr_en     <= 1'b0;
      state.miso      <= 1'b0;
      state.miso_oe   <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Serial data out
  // ************************************************************

  // Line and its enable straight from the decoder flops
  assign spi_miso    = state.miso;
  assign spi_miso_oe = state.miso_oe;

  // ************************************************************
  // Register storage
  // ************************************************************

  // Holds the limit and current code registers
  lsc_reg_bank u_reg_bank (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .wr_en        (state.wr_en),
    .wr_addr      (state.addr),
    .wr_data      (state.shift),
    .rd_addr      (state.addr),
    .rd_data      (rd_data),
    .limit_select (transient_limit_select),
    .limit_enable (limit_enable),
    .code_a       (switch_a_current_code),
    .code_b       (switch_b_current_code)
  );

  // ************************************************************
  // Per-switch limit enables
  // ************************************************************

  // Bit order: first switch at bit 0, third at bit 2
  assign switch_a_limit_enable = limit_enable[0];   // RQ5
  assign switch_b_limit_enable = limit_enable[1];   // RQ4
  assign switch_c_limit_enable = limit_enable[2];   // RQ3

endmodule : lsc_config_top

// ### verification/lsc_host_model.sv
// Host controller model driving the serial register port
`timescale 1ns/10ps
module lsc_host_model (
  input  wire logic core_clk,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // One frame, MSB first, four core cycles per half period; fewer bits abort
  task automatic frame(input logic [6:0] addr, input logic wr, input logic [7:0] wdata,
                       input int nbits, output logic [7:0] rdata);
    logic [15:0] shift;
    shift = {addr, wr, wdata};
    rdata = 8'h00;
    @(posedge core_clk);
    spi_cs_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (int i = 15; i >= 16 - nbits; i--) begin
      spi_mosi <= shift[i];
      repeat (4) @(posedge core_clk);
      if (i < 8) rdata[i] = spi_miso;
      spi_sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      spi_sclk <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi; // Deselected line does not keep last bit
    repeat (2) @(posedge core_clk);
  endtask : frame
endmodule : lsc_host_model

// ### verification/lsc_config_assertions.sv
// Port checker for the LED switch current configuration block
`timescale 1ns/10ps
module lsc_config_checker
  import lsc_pkg::*;
(
  input wire logic                          core_clk,
  input wire logic                          reset_n,
  input wire logic                          spi_sclk,
  input wire logic                          spi_cs_n,
  input wire logic                          spi_mosi,
  input wire logic                          spi_miso,
  input wire logic                          spi_miso_oe,
  input wire logic [lsc_pkg::LSC_SEL_W-1:0]  transient_limit_select,
  input wire logic                          switch_a_limit_enable,
  input wire logic                          switch_b_limit_enable,
  input wire logic                          switch_c_limit_enable,
  input wire logic [lsc_pkg::LSC_CODE_W-1:0] switch_a_current_code,
  input wire logic [lsc_pkg::LSC_CODE_W-1:0] switch_b_current_code
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ************************************************************
  // Port relations
  // ************************************************************
  a_reset_values: assert property ($rose(reset_n) |-> transient_limit_select == 3'h5
    && {switch_c_limit_enable, switch_b_limit_enable, switch_a_limit_enable} == 3'h0
    && switch_a_current_code == 10'h000 && switch_b_current_code == 10'h000)
    else $error("control outputs wrong after reset");
  a_select_hold: assert property (spi_cs_n [*3] |=> $stable(transient_limit_select))
    else $error("limit select moved outside a frame");
  a_enable_hold: assert property (spi_cs_n [*3] |=> $stable({switch_c_limit_enable,
    switch_b_limit_enable, switch_a_limit_enable})) else $error("enables moved idle");
  a_code_a_hold: assert property (spi_cs_n [*3] |=> $stable(switch_a_current_code))
    else $error("code a moved outside a frame");
  a_code_b_hold: assert property (spi_cs_n [*3] |=> $stable(switch_b_current_code))
    else $error("code b moved outside a frame");
  a_oe_follow: assert property ($fell(spi_cs_n) |-> ##[1:3] spi_miso_oe)
    else $error("miso enable late after select");
  a_miso_idle: assert property (spi_cs_n [*2] |-> !spi_miso_oe && !spi_miso)
    else $error("miso driven while deselected");
  a_miso_quiet: assert property ((!spi_sclk && !spi_cs_n) [*4] |=> $stable(spi_miso))
    else $error("miso moved without a clock fall");
  c_frame: cover property ($fell(spi_cs_n));
  c_select: cover property ($changed(transient_limit_select));
  c_code: cover property ($changed(switch_b_current_code));
endmodule : lsc_config_checker

bind lsc_config_top lsc_config_checker i_chk (.core_clk(core_clk), .reset_n(reset_n),
  .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe), .transient_limit_select(transient_limit_select),
  .switch_a_limit_enable(switch_a_limit_enable), .switch_b_limit_enable(switch_b_limit_enable),
  .switch_c_limit_enable(switch_c_limit_enable), .switch_a_current_code(switch_a_current_code),
  .switch_b_current_code(switch_b_current_code));

// ### verification/lsc_config_top_test.sv
// Self-checking bench for the LED switch current configuration block
`timescale 1ns/10ps
module lsc_config_top_test;
  import lsc_pkg::*;
  logic       core_clk = 1'b0;
  logic       reset_n  = 1'b0;
  logic       spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [2:0] sel;
  logic       en_a, en_b, en_c;
  logic [9:0] code_a, code_b;
  int         failures = 0;
  int         compares = 0;
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

  lsc_config_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .transient_limit_select(sel), .switch_a_limit_enable(en_a), .switch_b_limit_enable(en_b),
    .switch_c_limit_enable(en_c), .switch_a_current_code(code_a),
    .switch_b_current_code(code_b));
  lsc_host_model i_host (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  always #4 core_clk = ~core_clk;

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
    logic [7:0] x;
    i_host.frame(a, 1'b1, d, n, x);
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [7:0] ex);
    logic [7:0] x;
    i_host.frame(a, 1'b0, 8'h00, 16, x);
    `CHK("read data", ex, x)
  endtask : rdc
  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Watchdog: about forty frames of some 135 cycles, with wide margin
  initial begin
    #200000;
    failures++;
    complete_run();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    `CHK("select", 3'h5, sel)
    `CHK("enables", 3'h0, {en_c, en_b, en_a})
    `CHK("codes", 20'h00000, {code_a, code_b})
    rdc(7'h02, 8'h28);
    rdc(7'h03, 8'h00);
    rdc(7'h04, 8'h00);
    rdc(7'h05, 8'h00);
    rdc(7'h06, 8'h00);
    $display("test reset values done");
    wr(7'h03, 8'hFF);
    rdc(7'h03, 8'h03);
    wr(7'h04, 8'hA5);
    `CHK("code a", 10'h3A5, code_a)
    wr(7'h05, 8'hFE);
    rdc(7'h05, 8'h02);
    wr(7'h06, 8'h5A);
    rdc(7'h06, 8'h5A);
    `CHK("code b", 10'h25A, code_b)
    wr(7'h02, 8'hFF);
    rdc(7'h02, 8'h3F);
    $display("test code registers done");
    for (int i = 0; i < 3; i++) begin
      wr(7'h02, 8'h38 | (8'h01 << i));
      `CHK("enables", 3'h1 << i, {en_c, en_b, en_a})
    end
    for (int c = 0; c < 8; c++) begin
      wr(7'h02, {2'b11, c[2:0], 3'b101});
      `CHK("select", c[2:0], sel)
      rdc(7'h02, {2'b00, c[2:0], 3'b101});
    end
    $display("test limit register done");
    wr(7'h07, 8'h33);
    rdc(7'h07, 8'h00);
    wr(7'h04, 8'h11, 12);
    rdc(7'h04, 8'hA5);
    `CHK("code a", 10'h3A5, code_a)
    $display("test unmapped and abort done");
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    `CHK("select", 3'h5, sel)
    `CHK("enables", 3'h0, {en_c, en_b, en_a})
    `CHK("codes", 20'h00000, {code_a, code_b})
    rdc(7'h02, 8'h28);
    rdc(7'h04, 8'h00);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule : lsc_config_top_test
